/* File: core/ssp_pkg.sv */
`default_nettype none

package ssp_pkg;

    // clock and instruction cycle timing
    localparam int MCLK_PERIOD_NS = 5;
    localparam int TC_PERIOD_NS   = 20;
    localparam int TC_CLKS        = (TC_PERIOD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    // widths
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 8;
    localparam int SHIFT_W = 8;
    localparam int CNT_W   = 4;
    localparam int HALF_W  = 8;

    // shift clock half periods in mclk cycles
    localparam logic [HALF_W-1:0] HALF_TC2 = HALF_W'(TC_CLKS);
    localparam logic [HALF_W-1:0] HALF_TC4 = HALF_W'(2 * TC_CLKS);
    localparam logic [HALF_W-1:0] HALF_TC8 = HALF_W'(4 * TC_CLKS);

    // last bit index of a byte transfer
    localparam logic [CNT_W-1:0] LAST_BIT = 4'h7;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_MAIN_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS_WORD  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SHIFT_DATA   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_INT_STATUS   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK     = 8'h10;

    // field positions
    localparam int BUSY_BIT = 0;
    localparam int DONE_BIT = 0;

    // reset values
    localparam logic [DATA_W-1:0] CTRL_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] SHIFT_RESET = 8'h00;

    // main control register, bit 0 at the bottom
    typedef struct packed {
        logic [1:0] rsv;
        logic       clock_phase_select;
        logic       sck_cfg;
        logic       sdo_cfg;
        logic       clock_rate_sel_high;
        logic       clock_rate_sel_low;
        logic       serial_port_select;
    } ssp_ctrl_s;

    // register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ssp_req_s;

    // link pins toward the pads
    typedef struct packed {
        logic sck_out;
        logic sck_oe;
        logic sdo_out;
        logic sdo_oe;
    } ssp_pins_s;

    typedef enum logic {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } ssp_state_e;

    // half period of the master shift clock
    function automatic logic [HALF_W-1:0] half_clks(input logic rate_hi, input logic rate_lo);
        if (rate_hi) begin
            return HALF_TC8;
        end else if (rate_lo) begin
            return HALF_TC4;
        end else begin
            return HALF_TC2;
        end
    endfunction : half_clks

endpackage : ssp_pkg

`default_nettype wire

/* File: core/ssp_core.sv */
// Behaviour
// - eight-bit shift register with in, out, clock
// - internal clock is master, external is slave
// - port works only with select bit set
// - master rate 2, 4 or 8 cycles
// - busy write starts; cleared after eight bits
// - software busy clear stops shifting early
// - enabled interrupt on eight-bit completion
// - shift clock rests low when idle
// - master makes clock and starts exchanges
// - clock pin direction follows master or slave
// - pin config: internal clock, driven output
// - normal: sample rising, shift falling
// - alternate: sample falling, drive rising
// - phase flag in bit five, resets clear
`default_nettype none

module ssp_core (
    input  wire logic                        mclk,
    input  wire logic                        srst,
    input  wire ssp_pkg::ssp_req_s           bus_req,
    output logic [ssp_pkg::DATA_W-1:0]       rd_data,
    input  wire logic                        sck_in,
    input  wire logic                        sdi_in,
    output var ssp_pkg::ssp_pins_s           pins,
    output logic                             irq
);
    import ssp_pkg::*;

    ssp_ctrl_s               ctrl_r;
    ssp_state_e              state_r;
    logic [SHIFT_W-1:0]      shreg_r;
    logic [CNT_W-1:0]        bit_cnt_r;
    logic [HALF_W-1:0]       div_cnt_r;
    logic [HALF_W-1:0]       half;
    logic                    sck_r;
    logic                    sdo_r;
    logic                    in_lat_r;
    logic                    done_sts_r;
    logic                    done_msk_r;
    logic                    sck_s1_r;
    logic                    sck_s2_r;
    logic                    sck_s3_r;
    logic                    sdi_s1_r;
    logic                    sdi_s2_r;
    logic                    active;
    logic                    master;
    logic                    div_end;
    logic                    m_rise;
    logic                    m_fall;
    logic                    s_rise;
    logic                    s_fall;
    logic                    lead;
    logic                    trail;
    logic                    done_pulse;
    logic                    cancel;
    logic                    wr_ctrl;
    logic                    wr_stat;
    logic                    wr_data;
    logic                    wr_ists;
    logic                    wr_imsk;
    logic [DATA_W-1:0]       rd_nxt;

    // register decode
    assign wr_ctrl = bus_req.wr && (bus_req.addr == OFS_MAIN_CONTROL);
    assign wr_stat = bus_req.wr && (bus_req.addr == OFS_STATUS_WORD);
    assign wr_data = bus_req.wr && (bus_req.addr == OFS_SHIFT_DATA);
    assign wr_ists = bus_req.wr && (bus_req.addr == OFS_INT_STATUS);
    assign wr_imsk = bus_req.wr && (bus_req.addr == OFS_INT_MASK);
    assign cancel  = wr_stat && !bus_req.wdata[BUSY_BIT];

    // link input synchronisers
    always_ff @(posedge mclk) begin
        if (srst) begin
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_s3_r <= 1'b0;
            sdi_s1_r <= 1'b0;
            sdi_s2_r <= 1'b0;
        end else begin
            sck_s1_r <= sck_in;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            sdi_s1_r <= sdi_in;
            sdi_s2_r <= sdi_s1_r;
        end
    end

    // control register
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= bus_req.wdata;
        end
    end

    assign active = (state_r == ST_SHIFT) && ctrl_r.serial_port_select;
    assign master = ctrl_r.sck_cfg;
    assign half   = half_clks(ctrl_r.clock_rate_sel_high, ctrl_r.clock_rate_sel_low);
    assign div_end = (div_cnt_r == half - HALF_W'(1));

    // master shift clock generator
    always_ff @(posedge mclk) begin
        if (srst || !active || !master || cancel) begin
            sck_r     <= 1'b0;
            div_cnt_r <= '0;
        end else if (div_end) begin
            sck_r     <= ~sck_r;
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_r + HALF_W'(1);
        end
    end

    // edge events, master from own clock, slave from synced pin
    assign m_rise = active && master && div_end && !sck_r;
    assign m_fall = active && master && div_end && sck_r;
    assign s_rise = active && !master && sck_s2_r && !sck_s3_r;
    assign s_fall = active && !master && !sck_s2_r && sck_s3_r;
    assign lead   = m_rise || s_rise;
    assign trail  = m_fall || s_fall;
    assign done_pulse = trail && (bit_cnt_r == LAST_BIT);

    // busy state
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r <= ST_IDLE;
        end else if (wr_stat) begin
            state_r <= bus_req.wdata[BUSY_BIT] ? ST_SHIFT : ST_IDLE;
        end else if (done_pulse) begin
            state_r <= ST_IDLE;
        end
    end

    // bit counter
    always_ff @(posedge mclk) begin
        if (srst || state_r == ST_IDLE) begin
            bit_cnt_r <= '0;
        end else if (trail) begin
            bit_cnt_r <= bit_cnt_r + CNT_W'(1);
        end
    end

    // input latch for normal phase
    always_ff @(posedge mclk) begin
        if (srst) begin
            in_lat_r <= 1'b0;
        end else if (lead && !ctrl_r.clock_phase_select) begin
            in_lat_r <= sdi_s2_r;
        end
    end

    // shift register
    always_ff @(posedge mclk) begin
        if (srst) begin
            shreg_r <= SHIFT_RESET;
        end else if (wr_data) begin
            shreg_r <= bus_req.wdata;
        end else if (trail) begin
            if (ctrl_r.clock_phase_select) begin
                shreg_r <= {shreg_r[SHIFT_W-2:0], sdi_s2_r};
            end else begin
                shreg_r <= {shreg_r[SHIFT_W-2:0], in_lat_r};
            end
        end
    end

    // serial output
    always_ff @(posedge mclk) begin
        if (srst) begin
            sdo_r <= 1'b0;
        end else if (!active) begin
            sdo_r <= shreg_r[SHIFT_W-1];
        end else if (ctrl_r.clock_phase_select && lead) begin
            sdo_r <= shreg_r[SHIFT_W-1];
        end else if (!ctrl_r.clock_phase_select && trail) begin
            sdo_r <= shreg_r[SHIFT_W-2];
        end
    end

    // interrupt status and mask
    always_ff @(posedge mclk) begin
        if (srst) begin
            done_sts_r <= 1'b0;
        end else if (done_pulse) begin
            done_sts_r <= 1'b1;
        end else if (wr_ists && bus_req.wdata[DONE_BIT]) begin
            done_sts_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            done_msk_r <= 1'b0;
        end else if (wr_imsk) begin
            done_msk_r <= bus_req.wdata[DONE_BIT];
        end
    end

    assign irq = done_sts_r && done_msk_r;

    // read data, one cycle after the strobe
    always_comb begin
        rd_nxt = '0;
        unique case (bus_req.addr)
            OFS_MAIN_CONTROL: rd_nxt = ctrl_r;
            OFS_STATUS_WORD:  rd_nxt[BUSY_BIT] = (state_r == ST_SHIFT);
            OFS_SHIFT_DATA:   rd_nxt = shreg_r;
            OFS_INT_STATUS:   rd_nxt[DONE_BIT] = done_sts_r;
            OFS_INT_MASK:     rd_nxt[DONE_BIT] = done_msk_r;
            default:          rd_nxt = '0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_data <= '0;
        end else if (bus_req.rd) begin
            rd_data <= rd_nxt;
        end else begin
            rd_data <= '0;
        end
    end

    // pin drive
    always_comb begin
        pins.sck_out = sck_r;
        pins.sck_oe  = ctrl_r.serial_port_select && ctrl_r.sck_cfg;
        pins.sdo_out = sdo_r;
        pins.sdo_oe  = ctrl_r.serial_port_select && ctrl_r.sdo_cfg;
    end

    // checks
    logic [HALF_W-1:0] hi_len_r;
    logic [HALF_W-1:0] lo_len_r;

    always_ff @(posedge mclk) begin
        if (srst || !sck_r) begin
            hi_len_r <= '0;
        end else begin
            hi_len_r <= hi_len_r + HALF_W'(1);
        end
    end

    // low phase length of the master clock
    always_ff @(posedge mclk) begin
        if (srst || sck_r || !active || !master) begin
            lo_len_r <= '0;
        end else begin
            lo_len_r <= lo_len_r + HALF_W'(1);
        end
    end

    sequence cancel_seq;
        wr_stat && !bus_req.wdata[BUSY_BIT];
    endsequence

    sequence quiet_seq;
        (state_r == ST_IDLE) && !sck_r;
    endsequence

    sequence start_seq;
        wr_stat && bus_req.wdata[BUSY_BIT];
    endsequence

    sck_idle_a: assert property (@(posedge mclk) disable iff (srst)
        !active |=> !sck_r)
        else $error("shift clock high while idle");

    rate_len_a: assert property (@(posedge mclk) disable iff (srst)
        sck_r |-> hi_len_r < half)
        else $error("shift clock high phase too long");

    busy_done_a: assert property (@(posedge mclk) disable iff (srst)
        done_pulse && !wr_stat |=> state_r == ST_IDLE)
        else $error("busy not cleared after eighth bit");

    cancel_stop_a: assert property (@(posedge mclk) disable iff (srst)
        cancel_seq |=> quiet_seq ##1 quiet_seq)
        else $error("shifting continued after cancel");

    done_int_a: assert property (@(posedge mclk) disable iff (srst)
        done_pulse && done_msk_r && !wr_imsk |=> irq)
        else $error("no interrupt on completion");

    sel_gate_a: assert property (@(posedge mclk) disable iff (srst)
        !ctrl_r.serial_port_select |-> !pins.sck_oe && !pins.sdo_oe && !lead && !trail)
        else $error("port active without select");

    norm_shift_a: assert property (@(posedge mclk) disable iff (srst)
        trail && !ctrl_r.clock_phase_select && !wr_data
        |=> shreg_r[0] == $past(in_lat_r) && sdo_r == shreg_r[SHIFT_W-1])
        else $error("normal phase shift wrong");

    alt_drive_a: assert property (@(posedge mclk) disable iff (srst)
        lead && active && ctrl_r.clock_phase_select |=> sdo_r == $past(shreg_r[SHIFT_W-1]))
        else $error("alternate phase drive wrong");

    phase_reset_a: assert property (@(posedge mclk)
        srst |=> !ctrl_r.clock_phase_select)
        else $error("phase flag not clear after reset");

    oe_cfg_a: assert property (@(posedge mclk) disable iff (srst)
        ctrl_r.serial_port_select && !ctrl_r.sck_cfg |-> !pins.sck_oe && !sck_r)
        else $error("slave drives shift clock");

    busy_start_a: assert property (@(posedge mclk) disable iff (srst)
        start_seq |=> state_r == ST_SHIFT)
        else $error("busy write did not start shifting");

    bit_step_a: assert property (@(posedge mclk) disable iff (srst)
        trail && !done_pulse && !wr_stat |=> bit_cnt_r == $past(bit_cnt_r) + CNT_W'(1))
        else $error("bit counter did not advance");

    done_flag_a: assert property (@(posedge mclk) disable iff (srst)
        done_pulse |=> done_sts_r)
        else $error("done status not set");

    done_clear_a: assert property (@(posedge mclk) disable iff (srst)
        wr_ists && bus_req.wdata[DONE_BIT] && !done_pulse |=> !done_sts_r)
        else $error("done status not cleared");

    rate_low_a: assert property (@(posedge mclk) disable iff (srst)
        active && master && !sck_r |-> lo_len_r < half)
        else $error("shift clock low phase too long");

    slave_quiet_a: assert property (@(posedge mclk) disable iff (srst)
        !master |=> !sck_r)
        else $error("shift clock made in slave mode");

    idle_out_a: assert property (@(posedge mclk) disable iff (srst)
        !active |=> sdo_r == $past(shreg_r[SHIFT_W-1]))
        else $error("idle output not top data bit");

    alt_shift_a: assert property (@(posedge mclk) disable iff (srst)
        trail && ctrl_r.clock_phase_select && !wr_data |=> shreg_r[0] == $past(sdi_s2_r))
        else $error("alternate phase sample wrong");

    ctrl_load_a: assert property (@(posedge mclk) disable iff (srst)
        wr_ctrl |=> ctrl_r == $past(bus_req.wdata))
        else $error("control write lost");

endmodule : ssp_core

`default_nettype wire

/* File: verification/ssp_peer.sv */
`default_nettype none

module ssp_peer (
    input  wire logic       sck_line,
    input  wire logic       sdo_line,
    input  wire logic       alt,
    input  wire logic       gen,
    input  wire logic       go,
    input  wire logic [7:0] tx,
    output logic            sck_drv,
    output logic            sdi,
    output logic [7:0]      rx
);
    timeunit 1ns;
    timeprecision 100ps;
    int idx = 8;
    initial begin
        sck_drv = 1'b0;
        sdi     = 1'b0;
        rx      = 8'h00;
    end
    // frame start; own clock only in slave tests, low between frames
    always @(posedge go) begin
        idx = 0;
        sdi = tx[7];
        if (gen) begin
            repeat (8) begin
                #62.5 sck_drv = 1'b1;
                #62.5 sck_drv = 1'b0;
            end
        end
    end
    always @(posedge sck_line) begin
        if (alt && idx < 8) sdi = tx[7-idx];
        if (!alt) rx = {rx[6:0], sdo_line};
    end
    always @(negedge sck_line) begin
        if (alt) rx = {rx[6:0], sdo_line};
        idx++;
        if (idx < 8 && !alt) sdi = tx[7-idx];
        if (idx == 8) sdi <= #20 ~sdi;
    end
endmodule : ssp_peer

`default_nettype wire

/* File: verification/tb_sync_serial_shift_port.sv */
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end

module tb_sync_serial_shift_port;
    timeunit 1ns;
    timeprecision 100ps;
    import ssp_pkg::*;
    logic       mclk = 1'b0;
    logic       srst = 1'b1;
    ssp_req_s   bus_req = '0;
    logic [7:0] rd_data;
    ssp_pins_s  pins;
    logic       irq;
    logic       sck_drv, sdi, sck_line, sdo_line;
    logic       go = 1'b0, gen = 1'b0, alt = 1'b0, sck_q = 1'b0;
    logic [7:0] ptx = 8'h00, prx, h;
    int         bad_count = 0, compares = 0, hi_cnt = 0, rise_cnt = 0, hi, rs, n, r0;
    assign sck_line = pins.sck_oe ? pins.sck_out : sck_drv;
    assign sdo_line = pins.sdo_oe ? pins.sdo_out : 1'b1;

    ssp_core ssp_core_inst (.mclk(mclk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
        .sck_in(sck_line), .sdi_in(sdi), .pins(pins), .irq(irq));
    ssp_peer ssp_peer_inst (.sck_line(sck_line), .sdo_line(sdo_line), .alt(alt), .gen(gen),
        .go(go), .tx(ptx), .sck_drv(sck_drv), .sdi(sdi), .rx(prx));

    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        sck_q <= pins.sck_out;
        if (pins.sck_out) hi_cnt <= hi_cnt + 1;
        if (pins.sck_out && !sck_q) rise_cnt <= rise_cnt + 1;
    end

    task automatic wrap_up();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        bus_req.wr    <= 1'b1;
        @(posedge mclk);
        bus_req.wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus_req.addr <= a;
        bus_req.rd   <= 1'b1;
        @(posedge mclk);
        bus_req.rd   <= 1'b0;
        #1 d = rd_data;
    endtask : rd
    task automatic chk_rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        `CHK(nm, e, d)
    endtask : chk_rd
    task automatic wait_idle();
        logic [7:0] d;
        int k;
        k = 0;
        do begin
            rd(OFS_STATUS_WORD, d);
            k++;
        end while (d[0] !== 1'b0 && k < 400);
        if (k >= 400) begin
            bad_count++;
            wrap_up();
        end
    endtask : wait_idle
    task automatic xfer(input logic [7:0] c, input logic [7:0] dt, input logic [7:0] pt,
                        input logic g, output int hd, output int rd_n);
        int h0, q0;
        wr(OFS_INT_STATUS, 8'h01);
        wr(OFS_MAIN_CONTROL, c);
        wr(OFS_SHIFT_DATA, dt);
        ptx <= pt;
        alt <= c[5];
        gen <= g;
        h0 = hi_cnt;
        q0 = rise_cnt;
        wr(OFS_STATUS_WORD, 8'h01);
        go <= 1'b1;
        wait_idle();
        go <= 1'b0;
        hd   = hi_cnt - h0;
        rd_n = rise_cnt - q0;
        chk_rd("rx data", OFS_SHIFT_DATA, pt);
        `CHK("peer rx", dt, prx)
        chk_rd("done", OFS_INT_STATUS, 8'h01);
    endtask : xfer

    initial begin
        #200000 bad_count++;
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        chk_rd("ctrl", OFS_MAIN_CONTROL, CTRL_RESET);
        chk_rd("unmapped", 8'h14, 8'h00);
        `CHK("sck idle", 2'b00, {pins.sck_out, pins.sck_oe})
        wr(OFS_INT_MASK, 8'h01);
        for (int r = 0; r < 4; r++) begin
            xfer(8'h19 | 8'(r << 1), 8'hA5 ^ 8'(r), 8'h3C + 8'(r), 1'b0, hi, rs);
            h = r[1] ? HALF_TC8 : (r[0] ? HALF_TC4 : HALF_TC2);
            `CHK("high time", 8 * h, hi)
            `CHK("pulses", 8, rs)
            `CHK("irq", 1'b1, irq)
            `CHK("oe", 2'b11, {pins.sck_oe, pins.sdo_oe})
            wr(OFS_INT_STATUS, 8'h01);
            #1 `CHK("irq clr", 1'b0, irq)
        end
        wr(OFS_INT_MASK, 8'h00);
        xfer(8'h39, 8'hC3, 8'h5A, 1'b0, hi, rs);
        `CHK("masked irq", 1'b0, irq)
        xfer(8'h09, 8'h96, 8'hE1, 1'b1, hi, rs);
        `CHK("slave sck", 0, rs)
        `CHK("slave oe", 2'b01, {pins.sck_oe, pins.sdo_oe})
        xfer(8'h29, 8'h4B, 8'hD2, 1'b1, hi, rs);
        wr(OFS_INT_STATUS, 8'h01);
        wr(OFS_MAIN_CONTROL, 8'h1D);
        r0 = rise_cnt;
        wr(OFS_STATUS_WORD, 8'h01);
        for (n = 0; n < 400 && rise_cnt - r0 < 3; n++) @(posedge mclk);
        if (n >= 400) begin
            bad_count++;
            wrap_up();
        end
        wr(OFS_STATUS_WORD, 8'h00);
        chk_rd("cancel", OFS_STATUS_WORD, 8'h00);
        repeat (40) @(posedge mclk);
        `CHK("cut pulses", 3, rise_cnt - r0)
        `CHK("sck rest", 1'b0, pins.sck_out)
        chk_rd("no done", OFS_INT_STATUS, 8'h00);
        wr(OFS_MAIN_CONTROL, 8'h18);
        wr(OFS_STATUS_WORD, 8'h01);
        repeat (60) @(posedge mclk);
        `CHK("off pulses", 3, rise_cnt - r0)
        `CHK("off oe", 2'b00, {pins.sck_oe, pins.sdo_oe})
        wr(OFS_STATUS_WORD, 8'h00);
        wr(OFS_MAIN_CONTROL, 8'h11);
        #1 `CHK("tristate", 2'b10, {pins.sck_oe, pins.sdo_oe})
        wrap_up();
    end
endmodule : tb_sync_serial_shift_port

`default_nettype wire
